/* rtl/cgsm_target.sv */
/*
 * serial control target of a clock generator: indexed block write and
 * block read into control bytes 0, 1, 2 and the byte count at index 8,
 * plus the decoded output controls.
 * assumes the host drives the serial clock no faster than clk/8 and that
 * the sda pin is open drain, resolved outside this module.
 */
// What this block does
// - acknowledge write address D2 as target
// - ack index, count, data within count; store ascending
// - send byte count, then bytes upward
// - count and length come from byte 8
// - byte0 bit7 picks strap or bus select
// - byte0 bits6-4 independent spread enables
// - byte0 bits3-0 frequency code, strap reset
// - byte1 bits gate eight outputs, reset on
// - byte2 bits5,4 enable graphics pairs
// - byte2 bits3,1 map request B pins
`timescale 1ns/10ps
`default_nettype none

module cgsm_target (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [2:0] freq_strap,
	input wire logic clock_request_b_n,
	output cgsm_pkg::cgsm_ctrl_s ctrl
);

	// ************************************************************
	// pin synchronisers and edge detection
	// ************************************************************
	logic [cgsm_pkg::SYNC_BITS-1:0] pins_s;
	logic scl_s, sda_s, req_b_n_s;
	logic [2:0] strap_s;
	logic scl_prev_r, sda_prev_r;
	logic scl_rise, scl_fall, start_seen, stop_seen;

	// reset values match the idle pins: serial lines high, request B not asserted
	cgsm_sync #(.WIDTH(cgsm_pkg::SYNC_BITS), .RST_VAL(6'h07)) u_sync (
		.clk(clk),
		.reset_n(reset_n),
		.async_in({freq_strap, clock_request_b_n, sda_in, scl_in}),
		.sync_out(pins_s)
	);

	assign scl_s = pins_s[0];
	assign sda_s = pins_s[1];
	assign req_b_n_s = pins_s[2];
	assign strap_s = pins_s[5:3];

	// previous samples of the already synchronised lines
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_prev_r <= 1'b1;
			sda_prev_r <= 1'b1;
		end else begin
			scl_prev_r <= scl_s;
			sda_prev_r <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_prev_r;
	assign scl_fall = ~scl_s & scl_prev_r;
	assign start_seen = scl_s & scl_prev_r & sda_prev_r & ~sda_s;
	assign stop_seen = scl_s & scl_prev_r & ~sda_prev_r & sda_s;

	// ************************************************************
	// control bytes
	// ************************************************************
	logic [7:0] spread_and_freq_select_r;
	logic [7:0] output_enable_main_r;
	logic [7:0] graphics_enable_and_request_b_map_r;
	logic [7:0] byte_count_r;
	logic [1:0] strap_wait_r;
	logic strap_taken_r;
	logic [2:0] strap_latch_r;
	logic wr_en;
	logic [7:0] wr_idx, wr_data;

	// unmapped and reserved positions read as zero
	function automatic logic [7:0] read_byte(input logic [7:0] idx,
			input logic [7:0] b0, input logic [7:0] b1,
			input logic [7:0] b2, input logic [7:0] bc);
		case (idx)
			cgsm_pkg::IDX_SPREAD_FREQ: read_byte = b0;
			cgsm_pkg::IDX_OUT_ENABLE: read_byte = b1;
			cgsm_pkg::IDX_GFX_REQ_B: read_byte = b2 & cgsm_pkg::MASK_GFX_REQ_B;
			cgsm_pkg::IDX_BYTE_COUNT: read_byte = bc;
			default: read_byte = 8'h00;
		endcase
	endfunction

	// strap pins are caught once, after the synchroniser has settled
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			strap_wait_r <= 2'h0;
			strap_taken_r <= 1'b0;
			strap_latch_r <= 3'h0;
		end else if (!strap_taken_r) begin
			strap_wait_r <= strap_wait_r + 2'h1;
			strap_taken_r <= (strap_wait_r == cgsm_pkg::STRAP_SETTLE);
			// pins may move later; the strap code must not follow them
			if (strap_wait_r == cgsm_pkg::STRAP_SETTLE) begin
				strap_latch_r <= strap_s;
			end
		end
	end

	// bus writes land here; ones the host sends to reserved bits are lost
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			spread_and_freq_select_r <= cgsm_pkg::RST_SPREAD_FREQ;
			output_enable_main_r <= cgsm_pkg::RST_OUT_ENABLE;
			graphics_enable_and_request_b_map_r <= cgsm_pkg::RST_GFX_REQ_B;
			byte_count_r <= cgsm_pkg::RST_BYTE_COUNT;
		end else if (!strap_taken_r && strap_wait_r == cgsm_pkg::STRAP_SETTLE) begin
			spread_and_freq_select_r[2:0] <= strap_s;
		end else if (wr_en) begin
			case (wr_idx)
				cgsm_pkg::IDX_SPREAD_FREQ: spread_and_freq_select_r <= wr_data;
				cgsm_pkg::IDX_OUT_ENABLE: output_enable_main_r <= wr_data;
				cgsm_pkg::IDX_GFX_REQ_B:
					graphics_enable_and_request_b_map_r <= wr_data & cgsm_pkg::MASK_GFX_REQ_B;
				cgsm_pkg::IDX_BYTE_COUNT: byte_count_r <= wr_data;
				default: ;
			endcase
		end
	end

	// ************************************************************
	// serial protocol engine
	// ************************************************************
	cgsm_pkg::cgsm_state_e state_r;
	cgsm_pkg::cgsm_phase_e phase_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] shift_r;
	logic [7:0] index_r;
	logic [7:0] left_r;
	logic is_read_r;
	logic [7:0] cur_byte;

	assign cur_byte = read_byte(index_r, spread_and_freq_select_r, output_enable_main_r,
		graphics_enable_and_request_b_map_r, byte_count_r);

	// a data byte is stored only while the announced count lasts
	assign wr_en = (state_r == cgsm_pkg::CGSM_RX) && scl_fall && (bit_cnt_r == 4'h8) &&
		(phase_r == cgsm_pkg::CGSM_PH_DATA) && (left_r != 8'h00);
	assign wr_idx = index_r;
	assign wr_data = shift_r;

	// start and stop take priority over clock edges in the same cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= cgsm_pkg::CGSM_IDLE;
			phase_r <= cgsm_pkg::CGSM_PH_INDEX;
			bit_cnt_r <= 4'h0;
			shift_r <= 8'h00;
			index_r <= 8'h00;
			left_r <= 8'h00;
			is_read_r <= 1'b0;
		end else if (start_seen) begin
			state_r <= cgsm_pkg::CGSM_ADDR;
			bit_cnt_r <= 4'h0;
		end else if (stop_seen) begin
			state_r <= cgsm_pkg::CGSM_IDLE;
			phase_r <= cgsm_pkg::CGSM_PH_INDEX;
		end else if (scl_rise) begin
			case (state_r)
				cgsm_pkg::CGSM_ADDR, cgsm_pkg::CGSM_RX: begin
					shift_r <= {shift_r[6:0], sda_s};
					bit_cnt_r <= bit_cnt_r + 4'h1;
				end
				// host nack ends the read; it then sends stop
				cgsm_pkg::CGSM_TACK: if (sda_s) state_r <= cgsm_pkg::CGSM_IDLE;
				default: ;
			endcase
		end else if (scl_fall) begin
			case (state_r)
				cgsm_pkg::CGSM_ADDR: if (bit_cnt_r == 4'h8) begin
					if (shift_r == cgsm_pkg::WRITE_ADDR) begin
						state_r <= cgsm_pkg::CGSM_ACK;
						is_read_r <= 1'b0;
						phase_r <= cgsm_pkg::CGSM_PH_INDEX;
					end else if (shift_r == cgsm_pkg::READ_ADDR) begin
						state_r <= cgsm_pkg::CGSM_ACK;
						is_read_r <= 1'b1;
					end else begin
						state_r <= cgsm_pkg::CGSM_IDLE;
					end
				end
				cgsm_pkg::CGSM_RX: if (bit_cnt_r == 4'h8) begin
					state_r <= cgsm_pkg::CGSM_ACK;
					case (phase_r)
						cgsm_pkg::CGSM_PH_INDEX: begin
							index_r <= shift_r;
							phase_r <= cgsm_pkg::CGSM_PH_COUNT;
						end
						cgsm_pkg::CGSM_PH_COUNT: begin
							left_r <= shift_r;
							phase_r <= cgsm_pkg::CGSM_PH_DATA;
						end
						default: if (left_r != 8'h00) begin
							index_r <= index_r + 8'h01;
							left_r <= left_r - 8'h01;
						end else begin
							state_r <= cgsm_pkg::CGSM_IDLE; // bytes beyond the count get a nack
						end
					endcase
				end
				cgsm_pkg::CGSM_ACK: begin
					bit_cnt_r <= 4'h0;
					if (is_read_r) begin
						shift_r <= byte_count_r;
						left_r <= byte_count_r;
						state_r <= cgsm_pkg::CGSM_TX;
					end else begin
						state_r <= cgsm_pkg::CGSM_RX;
					end
				end
				cgsm_pkg::CGSM_TX: if (bit_cnt_r == 4'h7) begin
					state_r <= cgsm_pkg::CGSM_TACK;
				end else begin
					shift_r <= {shift_r[6:0], 1'b1};
					bit_cnt_r <= bit_cnt_r + 4'h1;
				end
				cgsm_pkg::CGSM_TACK: begin
					bit_cnt_r <= 4'h0;
					state_r <= cgsm_pkg::CGSM_TX;
					if (left_r != 8'h00) begin
						shift_r <= cur_byte;
						index_r <= index_r + 8'h01;
						left_r <= left_r - 8'h01;
					end else begin
						shift_r <= cgsm_pkg::IDLE_BYTE; // past the count the line stays released
					end
				end
				default: ;
			endcase
		end
	end

	// open drain: only ever pull low, never drive high
	assign sda_out = 1'b0;
	assign sda_oe = (state_r == cgsm_pkg::CGSM_ACK) ||
		((state_r == cgsm_pkg::CGSM_TX) && !shift_r[7]);

	// ************************************************************
	// decoded output controls
	// ************************************************************
	// registered so the clock tree controls never see a glitch
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl <= '0;
		end else begin
			ctrl.freq_select_origin <= spread_and_freq_select_r[cgsm_pkg::BIT_FREQ_ORIGIN];
			ctrl.graphics_spread_enable <= spread_and_freq_select_r[cgsm_pkg::BIT_GFX_SPREAD];
			ctrl.serial_ref_spread_enable <= spread_and_freq_select_r[cgsm_pkg::BIT_SREF_SPREAD];
			ctrl.processor_spread_enable <= spread_and_freq_select_r[cgsm_pkg::BIT_CPU_SPREAD];
			ctrl.processor_freq_code <= spread_and_freq_select_r[cgsm_pkg::BIT_FREQ_ORIGIN] ?
				spread_and_freq_select_r[3:0] : {1'b0, strap_latch_r};
			{ctrl.usb_clock_b, ctrl.usb_clock_a, ctrl.xtal_copy_c, ctrl.xtal_copy_b,
				ctrl.xtal_copy_a, ctrl.link_clock_out, ctrl.processor_pair_b,
				ctrl.processor_pair_a} <= output_enable_main_r;
			ctrl.graphics_pair_b <= graphics_enable_and_request_b_map_r[cgsm_pkg::BIT_GFX_PAIR_B];
			ctrl.graphics_pair_a <= graphics_enable_and_request_b_map_r[cgsm_pkg::BIT_GFX_PAIR_A];
			ctrl.serial_ref_2 <= !graphics_enable_and_request_b_map_r[cgsm_pkg::BIT_REQB_SREF_2] ||
				!req_b_n_s;
			ctrl.serial_ref_1 <= !graphics_enable_and_request_b_map_r[cgsm_pkg::BIT_REQB_SREF_1] ||
				!req_b_n_s;
		end
	end

endmodule

`default_nettype wire

/* pkg/cgsm_pkg.sv */
/*
 * constants, field layout and carrier types of the clock generator's
 * serial control target.
 * assumes a 50 MHz system clock and a host-driven serial clock.
 */
package cgsm_pkg;

	// ************************************************************
	// bus addresses
	// ************************************************************
	localparam logic [7:0] WRITE_ADDR = 8'hD2;
	localparam logic [7:0] READ_ADDR = 8'hD3;

	// ************************************************************
	// control byte indices
	// ************************************************************
	localparam logic [7:0] IDX_SPREAD_FREQ = 8'h00;
	localparam logic [7:0] IDX_OUT_ENABLE = 8'h01;
	localparam logic [7:0] IDX_GFX_REQ_B = 8'h02;
	localparam logic [7:0] IDX_BYTE_COUNT = 8'h08;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int BIT_FREQ_ORIGIN = 7;
	localparam int BIT_GFX_SPREAD = 6;
	localparam int BIT_SREF_SPREAD = 5;
	localparam int BIT_CPU_SPREAD = 4;
	localparam int BIT_PROCESSOR_FREQ_CODE_B3 = 3;
	localparam int BIT_GFX_PAIR_B = 5;
	localparam int BIT_GFX_PAIR_A = 4;
	localparam int BIT_REQB_SREF_2 = 3;
	localparam int BIT_REQB_SREF_1 = 1;

	// ************************************************************
	// reset values and writable masks
	// ************************************************************
	localparam logic [7:0] RST_SPREAD_FREQ = 8'h00;
	localparam logic [7:0] RST_OUT_ENABLE = 8'hFF;
	localparam logic [7:0] RST_GFX_REQ_B = 8'h30;
	localparam logic [7:0] RST_BYTE_COUNT = 8'h09;
	localparam logic [7:0] MASK_GFX_REQ_B = 8'h3A;
	localparam logic [7:0] IDLE_BYTE = 8'hFF;

	// ************************************************************
	// timing counts
	// ************************************************************
	localparam logic [1:0] STRAP_SETTLE = 2'h2;
	localparam int SYNC_BITS = 6;

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [2:0] {
		CGSM_IDLE = 3'b000,
		CGSM_ADDR = 3'b001,
		CGSM_ACK = 3'b011,
		CGSM_RX = 3'b010,
		CGSM_TX = 3'b110,
		CGSM_TACK = 3'b111
	} cgsm_state_e;

	typedef enum logic [1:0] {
		CGSM_PH_INDEX = 2'h0,
		CGSM_PH_COUNT = 2'h1,
		CGSM_PH_DATA = 2'h2
	} cgsm_phase_e;

	typedef struct packed {
		logic freq_select_origin;
		logic graphics_spread_enable;
		logic serial_ref_spread_enable;
		logic processor_spread_enable;
		logic [3:0] processor_freq_code;
		logic usb_clock_b;
		logic usb_clock_a;
		logic xtal_copy_c;
		logic xtal_copy_b;
		logic xtal_copy_a;
		logic link_clock_out;
		logic processor_pair_b;
		logic processor_pair_a;
		logic graphics_pair_b;
		logic graphics_pair_a;
		logic serial_ref_2;
		logic serial_ref_1;
	} cgsm_ctrl_s;

endpackage

/* rtl/cgsm_sync.sv */
/*
 * two-flop synchroniser bank for pins arriving from outside the clock.
 * assumes every input is a slow level relative to clk.
 */
`timescale 1ns/10ps
`default_nettype none

module cgsm_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	// ************************************************************
	// per-bit flop pairs
	// ************************************************************
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			logic meta_r;
			// first stage feeds only the second stage
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					meta_r <= RST_VAL[g];
					sync_out[g] <= RST_VAL[g];
				end else begin
					meta_r <= async_in[g];
					sync_out[g] <= meta_r;
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

/* tb/cgsm_checker.sv */
/* assertions on the serial control target's ports.
   assumes a bind onto cgsm_target and one clock domain. */
`timescale 1ns/10ps
`default_nettype none
module cgsm_checker (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic [2:0] freq_strap,
	input wire logic clock_request_b_n,
	input wire cgsm_pkg::cgsm_ctrl_s ctrl
);
	// ************************************************************
	// port relations
	// ************************************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	AST_OPEN_DRAIN: assert property (sda_out == 1'b0)
		else $error("sda data value not low");
	AST_RST_ENABLES: assert property ($rose(reset_n) |=> ctrl[11:2] == 10'h3FF)
		else $error("output enables not on after reset");
	AST_RST_SPREAD: assert property ($rose(reset_n) |=> ctrl[19:16] == 4'h0)
		else $error("origin or spread not off after reset");
	AST_CODE_B3: assert property (!ctrl.freq_select_origin |-> !ctrl.processor_freq_code[3])
		else $error("code bit3 set under strap origin");
	AST_REQ_ON: assert property ((!clock_request_b_n)[*5] |->
		ctrl.serial_ref_2 && ctrl.serial_ref_1)
		else $error("serial ref pair off while requested");
	// data may only turn while the serial clock is low
	AST_SDA_TURN: assert property ($changed(sda_oe) |-> !$past(scl_in))
		else $error("sda changed with scl high");
	AST_STORE_LOW: assert property ($past(reset_n, 3) && $changed(ctrl[11:2]) |->
		!$past(scl_in))
		else $error("control byte stored with scl high");
	AST_IDLE_RELEASE: assert property (scl_in[*8] |-> !sda_oe)
		else $error("sda held while bus idle");
	cover property ($rose(sda_oe));
	cover property (ctrl.freq_select_origin);
	cover property (!ctrl.serial_ref_1);
endmodule
bind cgsm_target cgsm_checker u_chk (.clk(clk), .reset_n(reset_n), .scl_in(scl_in),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .freq_strap(freq_strap),
	.clock_request_b_n(clock_request_b_n), .ctrl(ctrl));
`default_nettype wire

/* tb/cgsm_host.sv */
/* behavioural system host for the serial control link.
   assumes an open-drain sda with pull-up resolved by the bench. */
`timescale 1ns/10ps
`default_nettype none
module cgsm_host (
	input wire logic clk,
	input wire logic sda,
	output var logic scl,
	output var logic sda_pull
);
	// ************************************************************
	// bit level, 8 clk per scl period
	// ************************************************************
	int slow = 0;
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	// low phase stretched by slow to act as a lagging host
	task automatic bitx(input logic b, output logic r);
		@(posedge clk) scl <= 1'b0;
		@(posedge clk) sda_pull <= !b;
		repeat (4 + slow) @(posedge clk);
		scl <= 1'b1;
		repeat (2) @(posedge clk);
		@(negedge clk) r = sda;
	endtask
	// start when d0=0,d1=1; stop when d0=1,d1=0
	task automatic cond(input logic d0, input logic d1);
		@(posedge clk) scl <= 1'b0;
		@(posedge clk) sda_pull <= d0;
		repeat (5) @(posedge clk);
		scl <= 1'b1;
		repeat (4) @(posedge clk);
		sda_pull <= d1;
		repeat (6) @(posedge clk);
	endtask
	task automatic wbyte(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(v[i], r);
		bitx(1'b1, r);
		ack = !r;
	endtask
	// host acks all but the last byte
	task automatic rbyte(output logic [7:0] v, input logic last);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, r);
			v[i] = r;
		end
		bitx(last, r);
	endtask
endmodule
`default_nettype wire

/* tb/cgsm_target_tb_top.sv */
/* self-checking bench of the serial control target.
   assumes the host model and the bound checker beside it. */
`timescale 1ns/10ps
`default_nettype none
module cgsm_target_tb_top;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic reqb_n = 1'b1;
	logic [2:0] strap = 3'h5;
	logic [2:0] strap_l = 3'h5;
	logic sda_oe, sda_out, h_pull, ack;
	wire logic scl;
	wire logic sda;
	cgsm_pkg::cgsm_ctrl_s ctrl;
	int fails = 0;
	int n_checks = 0;
	logic [7:0] regs [0:8];
	logic [7:0] d;
	logic [7:0] q [$];
	// pull-up wire: low when any party pulls
	assign sda = !(h_pull || sda_oe);
	always #10 clk = ~clk;
	cgsm_target uut (.clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .freq_strap(strap),
		.clock_request_b_n(reqb_n), .ctrl(ctrl));
	cgsm_host host (.clk(clk), .sda(sda), .scl(scl), .sda_pull(h_pull));
	// ************************************************************
	// checking and model
	// ************************************************************
	task automatic chk(input string what, input logic [19:0] seen, input logic [19:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic init_regs();
		strap_l = strap;
		regs[0] = {5'h00, strap};
		regs[1] = 8'hFF;
		regs[2] = 8'h30;
		for (int i = 3; i < 8; i++) regs[i] = 8'h00;
		regs[8] = 8'h09;
	endtask
	function automatic cgsm_pkg::cgsm_ctrl_s exp_ctrl();
		logic [3:0] code;
		code = regs[0][7] ? regs[0][3:0] : {1'b0, strap_l};
		return {regs[0][7:4], code, regs[1], regs[2][5:4],
			!(regs[2][3] && reqb_n), !(regs[2][1] && reqb_n)};
	endfunction
	task automatic blk_wr(input logic [7:0] n, input logic [7:0] v [$]);
		host.cond(1'b0, 1'b1);
		host.wbyte(cgsm_pkg::WRITE_ADDR, ack);
		chk("write address ack", ack, 1'b1);
		host.wbyte(n, ack);
		chk("index ack", ack, 1'b1);
		host.wbyte(8'(v.size()), ack);
		chk("count ack", ack, 1'b1);
		foreach (v[i]) begin
			host.wbyte(v[i], ack);
			chk("data ack", ack, 1'b1);
			case (8'(n + i))
				8'h00, 8'h01, 8'h08: regs[8'(n + i)] = v[i];
				8'h02: regs[2] = v[i] & cgsm_pkg::MASK_GFX_REQ_B;
				default: ;
			endcase
		end
		host.cond(1'b1, 1'b0);
		repeat (8) @(posedge clk);
	endtask
	task automatic blk_rd(input logic [7:0] n);
		host.cond(1'b0, 1'b1);
		host.wbyte(cgsm_pkg::WRITE_ADDR, ack);
		host.wbyte(n, ack);
		host.cond(1'b0, 1'b1);
		host.wbyte(cgsm_pkg::READ_ADDR, ack);
		chk("read address ack", ack, 1'b1);
		host.rbyte(d, 1'b0);
		chk("count byte", d, regs[8]);
		for (int i = 0; i < regs[8]; i++) begin
			host.rbyte(d, i == regs[8] - 1);
			chk("read byte", d, (n + i <= 8) ? regs[n + i] : 8'h00);
		end
		host.cond(1'b1, 1'b0);
	endtask
	// ************************************************************
	// scenarios
	// ************************************************************
	initial begin
		repeat (100000) @(posedge clk);
		fails++;
		summarize();
	end
	initial begin
		void'($urandom(72711));
		@(posedge clk) strap <= 3'($urandom);
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		repeat (12) @(posedge clk);
		init_regs();
		chk("ctrl after reset", ctrl, exp_ctrl());
		blk_rd(8'h00);
		$display("test reset and default read done");
		// first pass is the corner: all spreads, byte1 outputs off, graphics pairs on, reserved bits set
		for (int k = 0; k < 5; k++) begin
			q = '{8'hF7, 8'h00, 8'hFF};
			if (k > 0) q = '{8'($urandom), 8'($urandom), 8'($urandom)};
			host.slow = k;
			@(posedge clk) reqb_n <= 1'($urandom);
			// strap pins move after capture; the latched code must hold
			strap <= 3'($urandom);
			blk_wr(8'h00, q);
			chk("ctrl after write", ctrl, exp_ctrl());
			blk_rd(8'h00);
		end
		host.slow = 0;
		$display("test random writes done");
		blk_wr(8'h02, '{8'h0A});
		for (int r = 0; r < 4; r++) begin
			@(posedge clk) reqb_n <= r[0];
			repeat (8) @(posedge clk);
			chk("request b gating", ctrl, exp_ctrl());
		end
		$display("test request b done");
		// lost bytes 3..7 then count, so the last byte lands at index 8
		blk_wr(8'h03, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h03});
		blk_rd(8'h06);
		blk_wr(8'h08, '{8'h02});
		blk_rd(8'h01);
		// a byte past a zero count is refused and stored nowhere
		host.cond(1'b0, 1'b1);
		host.wbyte(cgsm_pkg::WRITE_ADDR, ack);
		host.wbyte(8'h01, ack);
		host.wbyte(8'h00, ack);
		chk("zero count ack", ack, 1'b1);
		host.wbyte(8'h5A, ack);
		chk("byte past count ack", ack, 1'b0);
		host.cond(1'b1, 1'b0);
		repeat (8) @(posedge clk);
		chk("ctrl after refused byte", ctrl, exp_ctrl());
		$display("test byte count done");
		q = '{8'hD0, 8'hD4, 8'h52, 8'($urandom) | 8'h01};
		foreach (q[i]) begin
			host.cond(1'b0, 1'b1);
			host.wbyte(q[i][7:1] == 7'h69 ? 8'h00 : q[i], ack);
			chk("foreign address ack", ack, 1'b0);
			host.cond(1'b1, 1'b0);
		end
		$display("test foreign address done");
		@(posedge clk) reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		repeat (12) @(posedge clk);
		init_regs();
		chk("ctrl after second reset", ctrl, exp_ctrl());
		$display("test second reset done");
		summarize();
	end
endmodule
`default_nettype wire
